// [design/bpo_top.sv]
// Enhanced PWM output stage with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module bpo_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Sleep request from power management, asynchronous
  input  wire logic        sleep_in,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [5:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [5:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Output pins with drive enables
  output logic             out_a,
  output logic             out_a_oe,
  output logic             out_b,
  output logic             out_b_oe,
  output logic             out_c,
  output logic             out_c_oe,
  output logic             out_d,
  output logic             out_d_oe
);
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    // Software registers
    logic [7:0]          ctrl;      // pwm_mode_control
    logic [7:0]          duty_hi;   // duty_high_bits
    logic [7:0]          period;    // period_value
    logic [7:0]          tcon;      // period_timer_control
    logic [7:0]          tsel_lo;   // timer_select_low
    logic [1:0]          tsel_hi;   // timer_select_high
    logic [6:0]          dband;     // deadband_count
    logic [3:0]          steer;     // steering_control
    logic [3:0]          pdir;      // pin_direction_bit, 1 = input
    // Modulator core
    logic [7:0]          tmr;       // period_timer_count
    logic [5:0]          div;       // Clock divider and prescaler
    logic [9:0]          duty_sh;   // duty_shadow
    logic [1:0]          mode_q;    // Mode in force this period
    logic [1:0]          pol_q;     // Polarity in force this period
    logic [3:0]          steer_q;   // Steering in force this period
    bpo_pkg::bpo_state_t st;
    logic                pwm;       // Raw modulated signal
    logic [3:0]          out;       // Pin levels D..A
    logic [3:0]          oe;        // Pin enables D..A
    // Bus slave
    logic                awready;
    logic                wready;
    logic                aw_got;
    logic                w_got;
    logic [5:0]          awaddr;
    logic [7:0]          wdata;
    logic                wlane;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [7:0]          rdata;
    logic [1:0]          rresp;
  } bpo_core_t;

  bpo_core_t  cur;
  bpo_core_t  next_s;
  logic       sleep_q;    // Synchronised sleep level
  logic       run;        // Awake
  logic       tick;       // Timer increment
  logic       itick;      // Dead-band count enable
  logic       boundary;   // Period match at an increment
  logic [9:0] duty_new;   // Duty written by software
  logic       db_a;       // Dead-band delayed primary
  logic       db_b;       // Dead-band delayed complement
  logic [3:0] act;        // Active state per pin, D..A
  logic [3:0] use_pins;   // Pins owned by the mode
  logic [3:0] pol_mask;   // Inversion per pin

  // Word aligned register address
  function automatic logic [5:0] align(input logic [5:0] a);
    return {a[5:2], 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sleep input and dead-band units
  bpo_sync3 u_sleep (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     (sleep_in),
    .dout    (sleep_q)
  );

  // Primary output delay
  bpo_deadband u_db_a (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (run),
    .tick    (itick),
    .delay   (cur.dband),
    .raw     (cur.pwm),
    .act     (db_a)
  );

  // Complement output delay
  bpo_deadband u_db_b (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (run),
    .tick    (itick),
    .delay   (cur.dband),
    .raw     (~cur.pwm),
    .act     (db_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Timing strobes, all from the system clock
  always_comb begin
    run      = !sleep_q;
    tick     = run && cur.tcon[bpo_pkg::TCON_RUN]
               && cur.div == bpo_pkg::ps_last(cur.tcon[1:0]);
    itick    = cur.tcon[bpo_pkg::TCON_RUN];
    boundary = tick && cur.tmr == cur.period;
    duty_new = {cur.duty_hi, cur.ctrl[bpo_pkg::CTRL_DUTY_LO +: 2]};
  end

  // Pin roles per output mode
  always_comb begin
    act      = 4'h0;
    use_pins = 4'h0;
    pol_mask = {cur.pol_q[bpo_pkg::POL_BD], cur.pol_q[bpo_pkg::POL_AC],
                cur.pol_q[bpo_pkg::POL_BD], cur.pol_q[bpo_pkg::POL_AC]};
    case (cur.mode_q)
      bpo_pkg::OM_SINGLE: begin
        act      = {4{cur.pwm}};
        use_pins = cur.steer_q;
      end
      bpo_pkg::OM_HALF: begin
        act      = {2'h0, db_b, db_a};
        use_pins = 4'h3;
      end
      bpo_pkg::OM_FULL_FWD: begin
        act      = {cur.pwm, 1'b0, 1'b0, 1'b1};
        use_pins = 4'hf;
      end
      bpo_pkg::OM_FULL_REV: begin
        act      = {1'b0, 1'b1, cur.pwm, 1'b0};
        use_pins = 4'hf;
      end
      default: begin
        act      = 4'h0;
        use_pins = 4'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: modulator core, then bus slave
  always_comb begin
    next_s = cur;
    // Core holds completely while asleep
    if (run) begin
      if (cur.tcon[bpo_pkg::TCON_RUN]) begin
        next_s.div = tick ? 6'h00 : cur.div + 6'h01;
      end
      if (boundary) begin
        next_s.tmr     = 8'h00;
        next_s.duty_sh = duty_new;
        next_s.mode_q  = cur.ctrl[bpo_pkg::CTRL_MODE_LO +: 2];
        next_s.pol_q   = cur.ctrl[1:0];
        next_s.steer_q = cur.steer;
        next_s.pwm     = 1'b1;
      end else if (tick) begin
        next_s.tmr = cur.tmr + 8'h01;
      end
      // Time base reaching the duty clears the pin; duty zero never sets it
      if ({next_s.tmr, bpo_pkg::time_sub(next_s.div, cur.tcon[1:0])}
          == next_s.duty_sh) begin
        next_s.pwm = 1'b0;
      end
      // Enable sequencing
      if (cur.ctrl[3:2] != bpo_pkg::PWM_ON) begin
        next_s.st = bpo_pkg::ST_OFF;
      end else begin
        case (cur.st)
          bpo_pkg::ST_OFF:  next_s.st = bpo_pkg::ST_WAIT;
          bpo_pkg::ST_WAIT: begin
            if (boundary) begin
              next_s.st = bpo_pkg::ST_RUN;
            end
          end
          bpo_pkg::ST_RUN:  next_s.st = bpo_pkg::ST_RUN;
          default:          next_s.st = bpo_pkg::ST_OFF;
        endcase
      end
      // Pins: drive only when running, owned and direction cleared
      next_s.out = act ^ pol_mask;
      next_s.oe  = (cur.st == bpo_pkg::ST_RUN) ?
                   (use_pins & ~cur.pdir) : 4'h0;
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && cur.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane = s_axi_wstrb[0];
    end
    if (cur.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Register write once both halves are in
    if (cur.aw_got && cur.w_got && !cur.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = bpo_pkg::RESP_OKAY;
      case (align(cur.awaddr))
        bpo_pkg::OFS_CTRL: begin
          if (cur.wlane) next_s.ctrl = cur.wdata;
        end
        bpo_pkg::OFS_DUTY_HI: begin
          if (cur.wlane) next_s.duty_hi = cur.wdata;
        end
        bpo_pkg::OFS_PERIOD: begin
          if (cur.wlane) next_s.period = cur.wdata;
        end
        bpo_pkg::OFS_TCON: begin
          if (cur.wlane) next_s.tcon = cur.wdata & bpo_pkg::TCON_MASK;
        end
        bpo_pkg::OFS_TCOUNT: begin
          if (cur.wlane && run) next_s.tmr = cur.wdata;
        end
        bpo_pkg::OFS_DBAND: begin
          if (cur.wlane) next_s.dband = cur.wdata[6:0];
        end
        bpo_pkg::OFS_STEER: begin
          if (cur.wlane) next_s.steer = cur.wdata[3:0];
        end
        bpo_pkg::OFS_TSEL_LO: begin
          if (cur.wlane) next_s.tsel_lo = cur.wdata;
        end
        bpo_pkg::OFS_TSEL_HI: begin
          if (cur.wlane) next_s.tsel_hi = cur.wdata[1:0];
        end
        bpo_pkg::OFS_PDIR: begin
          if (cur.wlane) next_s.pdir = cur.wdata[3:0];
        end
        bpo_pkg::OFS_DSHADOW: begin
          next_s.bresp = bpo_pkg::RESP_OKAY;                          // Ignored
        end
        default: next_s.bresp = bpo_pkg::RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;

    // Read channel
    if (cur.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && cur.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = bpo_pkg::RESP_OKAY;
      case (align(s_axi_araddr))
        bpo_pkg::OFS_CTRL:    next_s.rdata = cur.ctrl;
        bpo_pkg::OFS_DUTY_HI: next_s.rdata = cur.duty_hi;
        bpo_pkg::OFS_DSHADOW: next_s.rdata = cur.duty_sh[9:2];
        bpo_pkg::OFS_PERIOD:  next_s.rdata = cur.period;
        bpo_pkg::OFS_TCON:    next_s.rdata = cur.tcon;
        bpo_pkg::OFS_TCOUNT:  next_s.rdata = cur.tmr;
        bpo_pkg::OFS_DBAND:   next_s.rdata = {1'b0, cur.dband};
        bpo_pkg::OFS_STEER:   next_s.rdata = {4'h0, cur.steer};
        bpo_pkg::OFS_TSEL_LO: next_s.rdata = cur.tsel_lo;
        bpo_pkg::OFS_TSEL_HI: next_s.rdata = {6'h00, cur.tsel_hi};
        bpo_pkg::OFS_PDIR:    next_s.rdata = {4'h0, cur.pdir};
        default: begin
          next_s.rdata = bpo_pkg::RST_BYTE;
          next_s.rresp = bpo_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset restores defaults and releases every pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur        <= '0;
      cur.period <= bpo_pkg::RST_PERIOD;
      cur.pdir   <= bpo_pkg::RST_PDIR;
      cur.st     <= bpo_pkg::ST_OFF;
    end else begin
      cur <= next_s;
    end
  end

  // Ports straight from flops
  assign s_axi_awready = cur.awready;
  assign s_axi_wready  = cur.wready;
  assign s_axi_bvalid  = cur.bvalid;
  assign s_axi_bresp   = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid  = cur.rvalid;
  assign s_axi_rdata   = {24'h000000, cur.rdata};
  assign s_axi_rresp   = cur.rresp;
  assign out_a         = cur.out[0];
  assign out_b         = cur.out[1];
  assign out_c         = cur.out[2];
  assign out_d         = cur.out[3];
  assign out_a_oe      = cur.oe[0];
  assign out_b_oe      = cur.oe[1];
  assign out_c_oe      = cur.oe[2];
  assign out_d_oe      = cur.oe[3];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sleep_hold_a: assert property (sleep_q |=> $stable(cur.tmr) && $stable(cur.duty_sh))
    else $error("Timer or duty moved during sleep");
  pin_hold_a: assert property (sleep_q |=> $stable(cur.out) && $stable(cur.oe))
    else $error("Pin changed during sleep");
  first_wait_a: assert property (run && cur.st != bpo_pkg::ST_RUN |=> cur.oe == 4'h0)
    else $error("Pin driven before first boundary");
  mode_off_a: assert property (run && cur.ctrl == 8'h00 ##1 run |=> cur.oe == 4'h0)
    else $error("Pins still driven after control cleared");
  half_unused_a: assert property (run && !boundary && cur.mode_q == bpo_pkg::OM_HALF
    |=> cur.oe[3:2] == 2'h0)
    else $error("Half bridge drove pin C or D");
  boundary_latch_a: assert property (boundary |=> cur.duty_sh == $past(duty_new)
    && cur.mode_q == $past(cur.ctrl[bpo_pkg::CTRL_MODE_LO +: 2]))
    else $error("Boundary did not latch duty and mode");
  duty_zero_a: assert property (boundary && duty_new == 10'h000 |=> !cur.pwm)
    else $error("Zero duty set the pin");
  fwd_roles_a: assert property (run && !boundary && cur.mode_q == bpo_pkg::OM_FULL_FWD
    |=> cur.out[0] == !$past(cur.pol_q[bpo_pkg::POL_AC])
    && cur.out[1] == $past(cur.pol_q[bpo_pkg::POL_BD]))
    else $error("Forward bridge pin roles wrong");

  half_run_c: cover property (cur.st == bpo_pkg::ST_RUN && cur.mode_q == bpo_pkg::OM_HALF);
  rev_run_c: cover property (cur.st == bpo_pkg::ST_RUN && cur.mode_q == bpo_pkg::OM_FULL_REV);
  sleep_run_c: cover property (sleep_q && cur.st == bpo_pkg::ST_RUN);
endmodule // bpo_top

// [common/bpo_pkg.sv]
// Constants, types and helpers for the bridge PWM output stage
package bpo_pkg;
// Functional notes
// - Sleep freezes timer and all modulator state
// - Driven pins keep their level during sleep
// - Timer resumes from held count after wake
// - All timing derives from the system clock
// - Reset restores registers, pins become inputs
// - Four output pins, ten bit duty
// - Two bit field selects output mode
// - Period, timer, duty registers set waveform
// - Per pin pair polarity is selectable
// - No output until first period boundary
// - Zero control register releases primary pin
// - Pins unused by mode are not driven
// - Half bridge: first modulated, second complement
// - Dead band delays active edge, instruction cycles
// - Dead band beyond pulse keeps output inactive
// - Single mode steers to any pin combination
// - Full bridge forward and reverse pin roles
// - Period match clears timer, sets pin, latches
// - Duty is high byte over two low bits

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite bus
  localparam int          ADDR_W      = 6;
  localparam logic [5:0]  OFS_CTRL    = 6'h00;  // pwm_mode_control
  localparam logic [5:0]  OFS_DUTY_HI = 6'h04;  // duty_high_bits
  localparam logic [5:0]  OFS_DSHADOW = 6'h08;  // duty_shadow, read only
  localparam logic [5:0]  OFS_PERIOD  = 6'h0c;  // period_value
  localparam logic [5:0]  OFS_TCON    = 6'h10;  // period_timer_control
  localparam logic [5:0]  OFS_TCOUNT  = 6'h14;  // period_timer_count
  localparam logic [5:0]  OFS_DBAND   = 6'h18;  // deadband_restart_control
  localparam logic [5:0]  OFS_STEER   = 6'h1c;  // steering_control
  localparam logic [5:0]  OFS_TSEL_LO = 6'h20;  // timer_select_low
  localparam logic [5:0]  OFS_TSEL_HI = 6'h24;  // timer_select_high
  localparam logic [5:0]  OFS_PDIR    = 6'h28;  // pin_direction_bit per pin
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Field positions and codes
  localparam int          CTRL_DUTY_LO = 4;     // duty_low_bits [5:4]
  localparam int          CTRL_MODE_LO = 6;     // output_mode_sel [7:6]
  localparam int          POL_AC       = 1;     // Pins A and C active low
  localparam int          POL_BD       = 0;     // Pins B and D active low
  localparam int          TCON_RUN     = 2;     // timer_run
  localparam logic [1:0]  PWM_ON       = 2'h3;  // module_mode_polarity[3:2]
  localparam logic [1:0]  OM_SINGLE    = 2'h0;
  localparam logic [1:0]  OM_FULL_FWD  = 2'h1;
  localparam logic [1:0]  OM_HALF      = 2'h2;
  localparam logic [1:0]  OM_FULL_REV  = 2'h3;
  localparam logic [1:0]  PS_1         = 2'h0;  // timer_prescale_sel codes
  localparam logic [1:0]  PS_4         = 2'h1;
  localparam logic [7:0]  TCON_MASK    = 8'h7f; // Top bit reads as zero

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_PERIOD = 8'hff;
  localparam logic [3:0]  RST_PDIR   = 4'hf;    // All pins inputs

  ////////////////////////////////////////////////////////////////////////
  // Timing: an instruction cycle is four system clocks
  localparam int          OSC_PER_INSTR = 4;
  localparam logic [1:0]  INSTR_LAST    = 2'(OSC_PER_INSTR - 1);
  localparam logic [5:0]  PS_LAST_1     = 6'h03;
  localparam logic [5:0]  PS_LAST_4     = 6'h0f;
  localparam logic [5:0]  PS_LAST_16    = 6'h3f;

  // Modulator sequencing
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,  // Modulator disabled, pins released
    ST_WAIT = 3'b010,  // Enabled, waiting for a period boundary
    ST_RUN  = 3'b100   // Waveform on the pins
  } bpo_state_t;

  // Last divider value before a timer increment
  function automatic logic [5:0] ps_last(input logic [1:0] sel);
    return (sel == PS_1) ? PS_LAST_1 : (sel == PS_4) ? PS_LAST_4 : PS_LAST_16;
  endfunction

  // Two low bits of the ten bit time base
  function automatic logic [1:0] time_sub(input logic [5:0] div, input logic [1:0] sel);
    return (sel == PS_1) ? div[1:0] : (sel == PS_4) ? div[3:2] : div[5:4];
  endfunction
endpackage

// [design/bpo_sync3.sv]
// Three flop synchroniser for an input from outside the clock domain
`timescale 1ns/1ps
module bpo_sync3 (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Asynchronous level in, filtered level out
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;  // First stage, read only by s2
    logic s2;
    logic s3;
    logic q;   // Accepted level
  } bpo_sync_t;

  bpo_sync_t cur;
  bpo_sync_t next_s;

  // Accept a change once stages two and three agree
  always_comb begin
    next_s    = cur;
    next_s.s1 = din;
    next_s.s2 = cur.s1;
    next_s.s3 = cur.s2;
    if (cur.s2 == cur.s3) begin
      next_s.q = cur.s3;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_s;
    end
  end

  assign dout = cur.q;
endmodule // bpo_sync3

// [design/bpo_deadband.sv]
// Dead-band delay on the rising active edge of one half-bridge output
`timescale 1ns/1ps
module bpo_deadband (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Control
  input  wire logic       run,    // Low while asleep: hold everything
  input  wire logic       tick,   // Count enable, high while the timer runs
  input  wire logic [6:0] delay,  // deadband_count
  // Signal
  input  wire logic       raw,
  output logic            act
);
  typedef struct packed {
    logic       prev;  // raw one cycle ago
    logic [6:0] cnt;   // Instruction cycles still to wait
    logic [1:0] sub;   // Clocks into the current instruction cycle
    logic       act;
  } bpo_db_t;

  bpo_db_t cur;
  bpo_db_t next_s;

  // Delay the rise, pass the fall at once
  always_comb begin
    next_s = cur;
    if (run) begin
      next_s.prev = raw;
      if (!raw) begin
        // Fall before the count expires keeps it inactive all period
        next_s.act = 1'b0;
        next_s.cnt = 7'h00;
        next_s.sub = 2'h0;
      end else if (!cur.prev) begin
        next_s.act = (delay == 7'h00);
        next_s.cnt = delay;
        next_s.sub = 2'h0;
      end else if (tick && cur.cnt != 7'h00) begin
        // Whole instruction cycles from the rise, so the delay never depends on phase
        if (cur.sub == bpo_pkg::INSTR_LAST) begin
          next_s.sub = 2'h0;
          next_s.cnt = cur.cnt - 7'h01;
          next_s.act = (cur.cnt == 7'h01);
        end else begin
          next_s.sub = cur.sub + 2'h1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_s;
    end
  end

  assign act = cur.act;

  // Checks
  dead_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run && raw && !cur.prev && delay != 7'h00 |=> !cur.act)
    else $error("Dead band output rose without delay");
  dead_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    run && raw && cur.prev && cur.cnt == 7'h01 && tick);
endmodule // bpo_deadband

// [tb/bpo_bridge_model.sv]
// Bridge switch drivers as seen from the modulator pins
`timescale 1ns/1ps
module bpo_bridge_model (
  // Pin levels and drive enables, D..A
  input  wire logic [3:0] lvl,
  input  wire logic [3:0] oe,
  // Wire levels and shoot-through flag
  output logic      [3:0] pin,
  output logic            shoot
);
  // Released pins fall to the pull-down level
  assign pin = lvl & oe;
  // Upper and lower switch of leg A/B both on
  assign shoot = pin[0] & pin[1];
endmodule // bpo_bridge_model

// [tb/bridge_pwm_output_stage_tb.sv]
// Self-checking bench for the bridge PWM output stage
`timescale 1ns/1ps
module bridge_pwm_output_stage_tb;
  logic clk_sys = 0, rstn = 0, sleep_in = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, w;
  logic [3:0] s_axi_wstrb = 4'hf, pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, shoot;
  logic out_a, out_a_oe, out_b, out_b_oe, out_c, out_c_oe, out_d, out_d_oe;
  int num_errors = 0, total_checks = 0, n;
  bpo_top i_dut (.*);
  bpo_bridge_model i_sw (.lvl({out_d, out_c, out_b, out_a}),
    .oe({out_d_oe, out_c_oe, out_b_oe, out_a_oe}), .pin(pin), .shoot(shoot));
  // Clock, 4 ns
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask
  // Bus wait ran out
  task lim(input logic busy);
    if (busy) begin
      $display("ERROR t=%0t got %h exp %h", $time, busy, 1'b0);
      num_errors++;
      conclude();
    end
  endtask
  // Register write over AXI4-Lite, response code into br
  task wr(input logic [5:0] a, input logic [7:0] d);
    int i;
    logic aw, dw, b;
    aw = 1;
    dw = 1;
    b = 1;
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (i = 0; i < 60 && b; i++) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 0;
        aw = 0;
      end
      if (dw && s_axi_wready) begin
        s_axi_wvalid <= 0;
        dw = 0;
      end
      if (s_axi_bvalid) begin
        s_axi_bready <= 0;
        br = s_axi_bresp;
        b = 0;
      end
    end
    lim(b);
    // Let an edge pass so the next call never reassigns bready in this step
    @(posedge clk_sys);
  endtask
  // Register read over AXI4-Lite into v and rr
  task rd(input logic [5:0] a);
    int i;
    logic ar, r;
    ar = 1;
    r = 1;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (i = 0; i < 60 && r; i++) begin
      @(posedge clk_sys);
      if (ar && s_axi_arready) begin
        s_axi_arvalid <= 0;
        ar = 0;
      end
      if (s_axi_rvalid) begin
        s_axi_rready <= 0;
        v = s_axi_rdata;
        rr = s_axi_rresp;
        r = 0;
      end
    end
    lim(r);
    // Let an edge pass so the next call never reassigns rready in this step
    @(posedge clk_sys);
  endtask
  // Length of one phase at level p on pin A
  task hi(input logic p, input int e);
    for (n = 0; n < 99 && pin[0] === p; n++) @(posedge clk_sys);
    for (n = 0; n < 99 && pin[0] !== p; n++) @(posedge clk_sys);
    for (n = 0; n < 99 && pin[0] === p; n++) @(posedge clk_sys);
    chk(32'(n), 32'(e));
  endtask
  // High cycles of pin b over two periods
  task cnt(input int b);
    n = 0;
    repeat (32) begin
      @(posedge clk_sys);
      n += int'(pin[b]) + (shoot ? 100 : 0);
    end
  endtask
  // Full bridge pin roles
  task fb(input logic [7:0] c, input logic [3:0] m, input logic [3:0] e);
    wr(bpo_pkg::OFS_CTRL, c);
    repeat (40) @(posedge clk_sys);
    chk(32'(pin & m), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1;
    @(posedge clk_sys);
    rd(bpo_pkg::OFS_PERIOD); chk(v, 32'hff);
    rd(bpo_pkg::OFS_PDIR); chk(v, 32'hf);
    rd(6'h3c); chk(32'(rr), 32'(bpo_pkg::RESP_SLVERR));
    wr(6'h3c, 8'h00);
    chk(32'(br), 32'(bpo_pkg::RESP_SLVERR));
    wr(bpo_pkg::OFS_PDIR, 8'h00);
    chk(32'(br), 32'(bpo_pkg::RESP_OKAY));
    wr(bpo_pkg::OFS_PERIOD, 8'h03); wr(bpo_pkg::OFS_DUTY_HI, 8'h01);
    wr(bpo_pkg::OFS_STEER, 8'h01); wr(bpo_pkg::OFS_TCON, 8'h04);
    wr(bpo_pkg::OFS_CTRL, 8'h2c);
    hi(1, 6); hi(0, 10);
    wr(bpo_pkg::OFS_CTRL, 8'h2e);
    repeat (40) @(posedge clk_sys);
    hi(0, 6);
    fb(8'h6c, 4'b0111, 4'b0001); fb(8'hec, 4'b1101, 4'b0100);
    wr(bpo_pkg::OFS_DBAND, 8'h02); wr(bpo_pkg::OFS_CTRL, 8'hac);
    repeat (40) @(posedge clk_sys);
    cnt(0); chk(32'(n), 32'd0);
    cnt(1); chk(32'(n), 32'd4);
    chk(32'(out_c_oe), 32'd0);
    sleep_in <= 1;
    repeat (8) @(posedge clk_sys);
    rd(bpo_pkg::OFS_TCOUNT); w = v; n = int'(pin);
    repeat (20) @(posedge clk_sys);
    rd(bpo_pkg::OFS_TCOUNT); chk(v, w);
    chk(32'(pin), 32'(n));
    sleep_in <= 0;
    wr(bpo_pkg::OFS_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk(32'(out_a_oe), 32'd0);
    conclude();
  end
endmodule // bridge_pwm_output_stage_tb
